// ===== rac_far_model.sv
// Far-side model: clock sources and the seconds counter behind the block.
// Assumes it shares aclk with the block; sources are derived from aclk.
`timescale 1ns/10ps
`default_nettype none

module rac_far_model (
  input  wire logic       aclk,
  input  wire logic       count_tick,
  output logic            xtal_clk_in,
  output logic            line_freq_in,
  output logic [7:0]      count_second,
  output logic            count_increment
);
  bit [7:0] div_r;
  bit [7:0] sec_r;
  bit       inc_r;

  ////////////////////////////////////////////////////////////////////////////
  // Free-running sources; locked to aclk so tick spacing is exact
  always_ff @(posedge aclk) begin
    div_r <= div_r + 8'h01;
  end
  assign xtal_clk_in  = div_r[1];
  assign line_freq_in = div_r[2]; // Period of 8 aclk cycles

  ////////////////////////////////////////////////////////////////////////////
  // Seconds step on tick, then report the step with counts already new
  always_ff @(posedge aclk) begin
    inc_r <= (count_tick === 1'b1);
    if (count_tick === 1'b1) begin
      sec_r <= sec_r + 8'h01;
    end
  end
  assign count_second    = sec_r;
  assign count_increment = inc_r;
endmodule

`default_nettype wire

// ===== rac_pkg.sv
// Constants and register map for the alarm and control block of a calendar clock.
// Assumes a 40 MHz bus clock and a host that reaches the registers over AXI4-Lite.
// Overview of operation
// R1 - BCD alarm hour: tens 0-2, ones 0-9
// R2 - Binary alarm hour uses whole byte
// R3 - Weekday survives reset, upper nibble reads zero
// R4 - Weekday writable only while counter unlocked
// R5 - Enable register resets zero, upper nibble zero
// R6 - Enable bits: weekday, hours, minutes, seconds
// R7 - Alarm when all enabled fields match
// R8 - Reading control clears alarm flag, request
// R9 - Flag updated on lock or count increment
// R10 - Control write resets the count prescaler
// R11 - Sleep wake cause survives reset, read clears
// R12 - Format bit selects BCD or binary
// R13 - Crystal source divides by 32768
// R14 - Line source divides by 60 or 50
// R15 - Interrupt enable gates alarm request
// R16 - Bit 7 shows alarm pending
// R17 - Daylight bit is storage only
// R18 - Unlock bit stops counter, allows writes
// R19 - Count registers writable only when unlocked
package rac_pkg;

  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned CLK_PERIOD_NS = 25;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_ALARM_HOUR_VALUE   = 8'hEA;
  localparam logic [7:0]  IDX_AWDAY  = 8'hEB;
  localparam logic [7:0]  IDX_AEN    = 8'hEC;
  localparam logic [7:0]  IDX_CTRL   = 8'hED;
  localparam logic [7:0]  IDX_IST    = 8'hEE;
  localparam logic [7:0]  IDX_IMASK  = 8'hEF;
  localparam logic [11:0] ADDR_ALARM_HOUR_VALUE  = {2'h0, IDX_ALARM_HOUR_VALUE, 2'h0};
  localparam logic [11:0] ADDR_AWDAY = {2'h0, IDX_AWDAY, 2'h0};
  localparam logic [11:0] ADDR_AEN   = {2'h0, IDX_AEN, 2'h0};
  localparam logic [11:0] ADDR_CTRL  = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [11:0] ADDR_IST   = {2'h0, IDX_IST, 2'h0};
  localparam logic [11:0] ADDR_IMASK = {2'h0, IDX_IMASK, 2'h0};

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int unsigned CTRL_ALARM  = 7;
  localparam int unsigned CTRL_INTEN  = 6;
  localparam int unsigned CTRL_BCD    = 5;
  localparam int unsigned CTRL_CLKSEL = 4;
  localparam int unsigned CTRL_FREQ   = 3;
  localparam int unsigned CTRL_DST    = 2;
  localparam int unsigned CTRL_SLEEP  = 1;
  localparam int unsigned CTRL_UNLOCK = 0;
  // Alarm enable fields
  localparam int unsigned EN_WDAY = 3;
  localparam int unsigned EN_HOUR = 2;
  localparam int unsigned EN_MIN  = 1;
  localparam int unsigned EN_SEC  = 0;
  // Interrupt status and mask fields
  localparam int unsigned IST_ALARM = 0;
  localparam int unsigned IST_WAKE  = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and limits
  localparam logic [3:0]  AEN_RST      = 4'h0;
  localparam logic        INTEN_RST    = 1'b0;
  localparam logic        UNLOCK_RST   = 1'b0;
  localparam logic [1:0]  IMASK_RST    = 2'h0;
  localparam logic [3:0]  BCD_TENS_MAX = 4'h2;
  localparam logic [3:0]  BCD_ONES_MAX = 4'h9;
  localparam logic [15:0] XTAL_DIV     = 16'h8000;
  localparam logic [15:0] LINE60_DIV   = 16'h003C;
  localparam logic [15:0] LINE50_DIV   = 16'h0032;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

endpackage

// ===== rac_top.sv
// Alarm set points, alarm enables, control/status and count prescaler of a calendar clock.
// Assumes the time counters sit outside, run on aclk and pulse count_increment after each step.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none

module rac_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        por_n,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        xtal_clk_in,
  input  wire logic        line_freq_in,
  input  wire logic [7:0]  count_second,
  input  wire logic [7:0]  count_minute,
  input  wire logic [7:0]  count_hour,
  input  wire logic [3:0]  count_weekday,
  input  wire logic [7:0]  alarm_second_setpoint,
  input  wire logic [7:0]  alarm_minute_setpoint,
  input  wire logic        count_increment,
  input  wire logic        sleep_mode,
  output logic             count_tick,
  output logic             count_write_allow,
  output logic             bcd_mode,
  output logic             osc_enable,
  output logic             alarm_irq,
  output logic             irq,
  output logic             sleep_recovery_reset
);

  ////////////////////////////////////////////////////////////////////////////
  // Whole module state
  typedef struct packed {
    logic [7:0]  alarm_hour_value;
    logic [3:0]  awday;
    logic [3:0]  aen;
    logic        flag;
    logic        int_en;
    logic        bcd;
    logic        clk_sel;
    logic        line_frequency_select;
    logic        dst;
    logic        sleep_cause;
    logic        unlock;
    logic        osc_en;
    logic [1:0]  ist;
    logic [1:0]  imask;
    logic [2:0]  xsync;
    logic [2:0]  lsync;
    logic [15:0] presc;
    logic        tick;
    logic        alarm_irq;
    logic        irq;
    logic        wake_pulse;
    logic        aw_held;
    logic [11:0] aw_addr;
    logic        w_held;
    logic [7:0]  wdata;
    logic        wlane0;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [1:0]  rresp;
  } rac_state_t;

  rac_state_t s_r;
  rac_state_t s_nxt;

  // Decoded events, shared with the checks below
  logic        wr_go;
  logic        rd_go;
  logic        ctrl_rd;
  logic        eval;
  logic        match;
  logic        alarm_evt;
  logic        src_edge;
  logic [15:0] div_limit;

  // Field compare honouring its enable
  function automatic logic field_ok(input logic en, input logic [7:0] a, input logic [7:0] b);
    field_ok = !en || (a == b);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    s_nxt = s_r;
    // Pin synchronisers; stage 0 feeds only stage 1
    s_nxt.xsync = {s_r.xsync[1:0], xtal_clk_in};
    s_nxt.lsync = {s_r.lsync[1:0], line_freq_in};

    // Bus handshakes
    wr_go   = s_r.aw_held && s_r.w_held && !s_r.bvalid;
    rd_go   = s_axi_arvalid && s_r.arready;
    ctrl_rd = rd_go && (s_axi_araddr == rac_pkg::ADDR_CTRL);
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.w_held = 1'b1;
      s_nxt.wdata  = s_axi_wdata[7:0];
      s_nxt.wlane0 = s_axi_wstrb[0];
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // Register writes; a cleared low byte lane stores nothing
    if (wr_go) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = rac_pkg::RESP_OKAY;
      if (s_r.aw_addr == rac_pkg::ADDR_ALARM_HOUR_VALUE) begin
        if (s_r.wlane0 && s_r.bcd) begin
          // Digits clamp to tens 2 and ones 9, so a bad BCD value still stores in range [R1] [R12]
          s_nxt.alarm_hour_value[7:4] = (s_r.wdata[7:4] > rac_pkg::BCD_TENS_MAX) ? rac_pkg::BCD_TENS_MAX : s_r.wdata[7:4];
          s_nxt.alarm_hour_value[3:0] = (s_r.wdata[3:0] > rac_pkg::BCD_ONES_MAX) ? rac_pkg::BCD_ONES_MAX : s_r.wdata[3:0];
        end else if (s_r.wlane0) begin
          s_nxt.alarm_hour_value = s_r.wdata; // [R2]
        end
      end else if (s_r.aw_addr == rac_pkg::ADDR_AWDAY) begin
        if (s_r.wlane0 && s_r.unlock) begin
          s_nxt.awday = s_r.wdata[3:0]; // [R4]
        end
      end else if (s_r.aw_addr == rac_pkg::ADDR_AEN) begin
        if (s_r.wlane0) begin
          s_nxt.aen = s_r.wdata[3:0]; // [R6]
        end
      end else if (s_r.aw_addr == rac_pkg::ADDR_CTRL) begin
        if (s_r.wlane0) begin
          s_nxt.int_en   = s_r.wdata[rac_pkg::CTRL_INTEN];
          s_nxt.bcd      = s_r.wdata[rac_pkg::CTRL_BCD];    // [R12]
          s_nxt.clk_sel  = s_r.wdata[rac_pkg::CTRL_CLKSEL];
          s_nxt.line_frequency_select = s_r.wdata[rac_pkg::CTRL_FREQ];
          s_nxt.dst      = s_r.wdata[rac_pkg::CTRL_DST];    // [R17]
          s_nxt.unlock   = s_r.wdata[rac_pkg::CTRL_UNLOCK];
        end
      end else if (s_r.aw_addr == rac_pkg::ADDR_IST) begin
        if (s_r.wlane0) begin
          s_nxt.ist = s_r.ist & ~s_r.wdata[1:0];
        end
      end else if (s_r.aw_addr == rac_pkg::ADDR_IMASK) begin
        if (s_r.wlane0) begin
          s_nxt.imask = s_r.wdata[1:0];
        end
      end else begin
        s_nxt.bresp = rac_pkg::RESP_SLVERR;
      end
    end

    // Register reads; unmapped answers zero with an error
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (rd_go) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = rac_pkg::RESP_OKAY;
      if (s_axi_araddr == rac_pkg::ADDR_ALARM_HOUR_VALUE) begin
        s_nxt.rdata = s_r.alarm_hour_value;
      end else if (s_axi_araddr == rac_pkg::ADDR_AWDAY) begin
        s_nxt.rdata = {4'h0, s_r.awday}; // [R3]
      end else if (s_axi_araddr == rac_pkg::ADDR_AEN) begin
        s_nxt.rdata = {4'h0, s_r.aen}; // [R5]
      end else if (s_axi_araddr == rac_pkg::ADDR_CTRL) begin
        // Bit 7 shows the pending alarm as it stood before this read [R16]
        s_nxt.rdata = {s_r.flag, s_r.int_en, s_r.bcd, s_r.clk_sel,
                       s_r.line_frequency_select, s_r.dst, s_r.sleep_cause, s_r.unlock};
      end else if (s_axi_araddr == rac_pkg::ADDR_IST) begin
        s_nxt.rdata = {6'h00, s_r.ist};
      end else if (s_axi_araddr == rac_pkg::ADDR_IMASK) begin
        s_nxt.rdata = {6'h00, s_r.imask};
      end else begin
        s_nxt.rdata = 8'h00;
        s_nxt.rresp = rac_pkg::RESP_SLVERR;
      end
    end

    // Prescaler; the source edge is taken from the settled stages only
    div_limit = s_r.clk_sel ? (s_r.line_frequency_select ? rac_pkg::LINE50_DIV : rac_pkg::LINE60_DIV)
                            : rac_pkg::XTAL_DIV; // [R13] [R14]
    src_edge  = s_r.clk_sel ? (s_r.lsync[1] && !s_r.lsync[2]) : (s_r.xsync[1] && !s_r.xsync[2]);
    s_nxt.tick = 1'b0;
    if (wr_go && s_r.wlane0 && (s_r.aw_addr == rac_pkg::ADDR_CTRL)) begin
      s_nxt.presc = 16'h0000; // [R10]
    end else if (src_edge) begin
      if (s_r.presc == div_limit - 16'h0001) begin
        s_nxt.presc = 16'h0000;
        s_nxt.tick  = !s_r.unlock; // Stopped while unlocked [R18]
      end else begin
        s_nxt.presc = s_r.presc + 16'h0001;
      end
    end

    // Alarm compare, looked at only on a count step or on locking [R7] [R9]
    match = (s_r.aen != 4'h0)
         && field_ok(s_r.aen[rac_pkg::EN_SEC], alarm_second_setpoint, count_second)
         && field_ok(s_r.aen[rac_pkg::EN_MIN], alarm_minute_setpoint, count_minute)
         && field_ok(s_r.aen[rac_pkg::EN_HOUR], s_r.alarm_hour_value, count_hour)
         && field_ok(s_r.aen[rac_pkg::EN_WDAY], {4'h0, s_r.awday}, {4'h0, count_weekday});
    eval      = count_increment || (s_r.unlock && !s_nxt.unlock);
    alarm_evt = eval && match;
    // Read clears, but a fresh alarm in the same cycle wins [R8]
    if (alarm_evt) begin
      s_nxt.flag = 1'b1;
    end else if (ctrl_rd) begin
      s_nxt.flag = 1'b0;
    end
    // Wake cause only while asleep; set wins over the read clear [R11]
    s_nxt.wake_pulse = alarm_evt && sleep_mode;
    if (alarm_evt && sleep_mode) begin
      s_nxt.sleep_cause = 1'b1;
    end else if (ctrl_rd) begin
      s_nxt.sleep_cause = 1'b0;
    end
    // Sticky status for the mask-gated line; set wins over write-one clear
    if (alarm_evt) begin
      s_nxt.ist[rac_pkg::IST_ALARM] = 1'b1;
    end
    if (alarm_evt && sleep_mode) begin
      s_nxt.ist[rac_pkg::IST_WAKE] = 1'b1;
    end

    // Ready flags: one write and one read at a time
    s_nxt.awready = !s_nxt.aw_held && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.w_held && !s_nxt.bvalid;
    s_nxt.arready = !s_nxt.rvalid;

    // Bus-side reset keeps set points, format, source and wake cause [R3] [R11]
    if (!aresetn) begin
      s_nxt.aen        = rac_pkg::AEN_RST; // [R5]
      s_nxt.int_en     = rac_pkg::INTEN_RST;
      s_nxt.unlock     = rac_pkg::UNLOCK_RST;
      s_nxt.imask      = rac_pkg::IMASK_RST;
      s_nxt.ist        = 2'h0;
      s_nxt.presc      = 16'h0000;
      s_nxt.tick       = 1'b0;
      s_nxt.wake_pulse = 1'b0;
      s_nxt.aw_held    = 1'b0;
      s_nxt.w_held     = 1'b0;
      s_nxt.bvalid     = 1'b0;
      s_nxt.rvalid     = 1'b0;
      s_nxt.awready    = 1'b0;
      s_nxt.wready     = 1'b0;
      s_nxt.arready    = 1'b0;
    end
    // Power-on clears everything but osc_en, which then follows the cleared clk_sel, giving the kept fields a defined start
    if (!por_n) begin
      s_nxt = '0;
    end

    // Output flops follow the settled next state
    s_nxt.alarm_irq = s_nxt.flag && s_nxt.int_en; // [R15]
    s_nxt.irq       = |(s_nxt.ist & s_nxt.imask);
    s_nxt.osc_en    = !s_nxt.clk_sel; // [R13] [R14]
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge aclk) begin
    s_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flops
  assign s_axi_awready        = s_r.awready;
  assign s_axi_wready         = s_r.wready;
  assign s_axi_bresp          = s_r.bresp;
  assign s_axi_bvalid         = s_r.bvalid;
  assign s_axi_arready        = s_r.arready;
  assign s_axi_rdata          = {24'h000000, s_r.rdata};
  assign s_axi_rresp          = s_r.rresp;
  assign s_axi_rvalid         = s_r.rvalid;
  assign count_tick           = s_r.tick;
  assign count_write_allow    = s_r.unlock; // [R19]
  assign bcd_mode             = s_r.bcd;
  assign osc_enable           = s_r.osc_en;
  assign alarm_irq            = s_r.alarm_irq;
  assign irq                  = s_r.irq;
  assign sleep_recovery_reset = s_r.wake_pulse;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !por_n);

  sequence wr_to(logic [11:0] a);
    wr_go && s_r.wlane0 && (s_r.aw_addr == a);
  endsequence

  sequence rd_of(logic [11:0] a);
    rd_go && (s_axi_araddr == a);
  endsequence

  // Set points, enables and control readback
  AST_BCD_HOUR: assert property (wr_to(rac_pkg::ADDR_ALARM_HOUR_VALUE) and (s_r.bcd) |=> // [R1]
    (s_r.alarm_hour_value[7:4] <= 4'h2) && (s_r.alarm_hour_value[3:0] <= 4'h9))
    else $error("BCD alarm hour digit out of range");
  AST_BIN_HOUR: assert property (wr_to(rac_pkg::ADDR_ALARM_HOUR_VALUE) and (!s_r.bcd) |=> // [R2]
    s_r.alarm_hour_value == $past(s_r.wdata))
    else $error("binary alarm hour not stored whole");
  AST_WDAY_UPPER: assert property (rd_of(rac_pkg::ADDR_AWDAY) |=> s_axi_rdata[7:4] == 4'h0) // [R3]
    else $error("weekday upper nibble not zero");
  AST_WDAY_LOCKED: assert property (wr_to(rac_pkg::ADDR_AWDAY) and (!s_r.unlock) |=> $stable(s_r.awday)) // [R4]
    else $error("weekday written while locked");
  AST_AEN_UPPER: assert property (rd_of(rac_pkg::ADDR_AEN) |=> s_axi_rdata[7:4] == 4'h0) // [R5]
    else $error("enable upper nibble not zero");
  AST_NO_ENABLE: assert property ((s_r.aen == 4'h0) && !s_r.flag |=> !s_r.flag) // [R7]
    else $error("alarm raised with no field enabled");
  AST_ALARM_SET: assert property (alarm_evt |=> s_r.flag ##0 (s_r.alarm_irq == s_r.int_en)) // [R9]
    else $error("alarm match did not set flag");
  AST_FLAG_QUIET: assert property (!eval && !s_r.flag |=> !s_r.flag) // [R9]
    else $error("flag set outside evaluation");
  AST_READ_CLEAR: assert property (ctrl_rd && !alarm_evt |=> !s_r.flag && !s_r.alarm_irq) // [R8]
    else $error("control read did not clear alarm");
  AST_FLAG_READBACK: assert property (rd_of(rac_pkg::ADDR_CTRL) |=> s_axi_rdata[7] == $past(s_r.flag)) // [R16]
    else $error("bit 7 does not show pending alarm");
  AST_IRQ_GATE: assert property (!s_r.int_en |-> !s_r.alarm_irq) // [R15]
    else $error("alarm request while disabled");

  // Prescaler, tick pacing and sleep wake cause; each tick must end a full divide count
  AST_PRESC_RESET: assert property (wr_to(rac_pkg::ADDR_CTRL) |=> (s_r.presc == 16'h0000) ##1 !s_r.tick) // [R10]
    else $error("prescaler not reset by control write");
  AST_TICK_LOCKED: assert property (s_r.unlock |=> !s_r.tick) // [R18]
    else $error("count tick while unlocked");
  AST_XTAL_DIV: assert property (s_r.tick && !s_r.clk_sel |-> // [R13]
    $past(s_r.presc) == rac_pkg::XTAL_DIV - 16'h0001)
    else $error("crystal tick off its boundary");
  AST_LINE_DIV: assert property (s_r.tick && s_r.clk_sel |-> // [R14]
    $past(s_r.presc) == (s_r.line_frequency_select ? rac_pkg::LINE50_DIV : rac_pkg::LINE60_DIV) - 16'h0001)
    else $error("line tick off its count");
  AST_LINE_LIMIT: assert property (s_r.clk_sel && s_r.line_frequency_select |-> s_r.presc <= 16'h0032) // [R14]
    else $error("line prescaler beyond 50");
  AST_WAKE: assert property (alarm_evt && sleep_mode |=> s_r.sleep_cause && s_r.wake_pulse ##1 !s_r.wake_pulse) // [R11]
    else $error("sleep wake cause not recorded");

  // Stored fields follow the written byte; the read side relies on it
  AST_WDAY_WRITE: assert property (wr_to(rac_pkg::ADDR_AWDAY) and (s_r.unlock) |=> // [R4]
    s_r.awday == $past(s_r.wdata[3:0]))
    else $error("weekday not written while unlocked");
  AST_AEN_WRITE: assert property (wr_to(rac_pkg::ADDR_AEN) |=> s_r.aen == $past(s_r.wdata[3:0])) // [R6]
    else $error("alarm enables not stored");
  AST_FORMAT: assert property (wr_to(rac_pkg::ADDR_CTRL) |=> // [R12]
    bcd_mode == $past(s_r.wdata[rac_pkg::CTRL_BCD]))
    else $error("format bit not applied");
  AST_OSC: assert property (wr_to(rac_pkg::ADDR_CTRL) |=> // [R13] [R14]
    osc_enable == !$past(s_r.wdata[rac_pkg::CTRL_CLKSEL]))
    else $error("oscillator enable does not follow source");

endmodule

`default_nettype wire

// ===== rac_top_tb_top.sv
// Self-checking bench for the alarm and control block over AXI4-Lite.
// Assumes the far-side model steps the seconds count on each tick.
`timescale 1ns/10ps
`default_nettype none

module rac_top_tb_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        por_n = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sleep_mode = 1'b0;
  logic [7:0]  count_minute = 8'h00, count_hour = 8'h00;
  logic [7:0]  alarm_second_setpoint = 8'h00, alarm_minute_setpoint = 8'h00;
  logic [3:0]  count_weekday = 4'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rdat;
  logic [7:0]  count_second;
  logic        xtal_clk_in, line_freq_in, count_increment, count_tick, count_write_allow;
  logic        bcd_mode, osc_enable, alarm_irq, irq, sleep_recovery_reset;
  int          fails = 0, compares = 0, wakes = 0, cyc = 0, gap = 0, n, k;

  rac_top u_dut (.aclk, .aresetn, .por_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .xtal_clk_in, .line_freq_in, .count_second, .count_minute,
    .count_hour, .count_weekday, .alarm_second_setpoint, .alarm_minute_setpoint,
    .count_increment, .sleep_mode, .count_tick, .count_write_allow, .bcd_mode, .osc_enable,
    .alarm_irq, .irq, .sleep_recovery_reset);
  rac_far_model u_far (.aclk, .count_tick, .xtal_clk_in, .line_freq_in, .count_second,
    .count_increment);

  ////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  always #12.5 aclk = ~aclk;
  // Wake pulses and tick spacing, counted on the sampling edge
  always @(posedge aclk) begin
    if (sleep_recovery_reset === 1'b1) wakes <= wakes + 1;
    if (count_tick === 1'b1) begin
      gap <= cyc + 1;
      cyc <= 0;
    end else cyc <= cyc + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus tasks; every change is made just after a rising edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      fails++;
    end
  endtask
  task automatic rc(input string nm, input logic [11:0] a, input logic [7:0] e);
    rd(a);
    chk(nm, {24'h000000, e}, rdat);
  endtask
  // Bounded wait for the next tick
  task automatic wt();
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (count_tick !== 1'b1 && n < 2000);
  endtask
  task automatic stop_test();
    if (fails == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Hang guard, well beyond the few thousand cycles the tests need
  initial begin
    repeat (60000) @(posedge aclk);
    fails++;
    stop_test();
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge aclk);
    por_n <= 1'b1;
    aresetn <= 1'b1;
    rc("aen", rac_pkg::ADDR_AEN, 8'h00);
    rc("ctrl", rac_pkg::ADDR_CTRL, 8'h00);
    chk("osc", 1, osc_enable);
    wr(rac_pkg::ADDR_AWDAY, 8'hF5);
    chk("bresp", rac_pkg::RESP_OKAY, resp);
    rc("wday_locked", rac_pkg::ADDR_AWDAY, 8'h00);
    wr(rac_pkg::ADDR_CTRL, 8'h01);
    chk("wr_allow", 1, count_write_allow);
    wr(rac_pkg::ADDR_AWDAY, 8'hF5);
    rc("wday", rac_pkg::ADDR_AWDAY, 8'h05);
    wr(rac_pkg::ADDR_CTRL, 8'h21);
    chk("bcd", 1, bcd_mode);
    wr(rac_pkg::ADDR_ALARM_HOUR_VALUE, 8'h39);
    rc("alarm_hour_value_bcd", rac_pkg::ADDR_ALARM_HOUR_VALUE, 8'h29);
    wr(rac_pkg::ADDR_ALARM_HOUR_VALUE, 8'h1C);
    rc("alarm_hour_value_bcd", rac_pkg::ADDR_ALARM_HOUR_VALUE, 8'h19);
    wr(rac_pkg::ADDR_CTRL, 8'h01);
    wr(rac_pkg::ADDR_ALARM_HOUR_VALUE, 8'hAB);
    rc("alarm_hour_value_bin", rac_pkg::ADDR_ALARM_HOUR_VALUE, 8'hAB);
    wr(rac_pkg::ADDR_AEN, 8'hFF);
    rc("aen", rac_pkg::ADDR_AEN, 8'h0F);
    wr(rac_pkg::ADDR_AEN, 8'h00);
    count_hour <= 8'hAB;
    wr(rac_pkg::ADDR_CTRL, 8'h40);
    repeat (3) @(posedge aclk);
    chk("no_enables", 0, alarm_irq);
    // Enable write alone must not evaluate the match
    wr(rac_pkg::ADDR_AEN, 8'h04);
    repeat (20) @(posedge aclk);
    chk("no_eval", 0, alarm_irq);
    wr(rac_pkg::ADDR_CTRL, 8'h41);
    wr(rac_pkg::ADDR_CTRL, 8'h40);
    repeat (3) @(posedge aclk);
    chk("alarm_irq", 1, alarm_irq);
    wr(rac_pkg::ADDR_IMASK, 8'h01);
    repeat (2) @(posedge aclk);
    chk("irq", 1, irq);
    rc("ctrl", rac_pkg::ADDR_CTRL, 8'hC0);
    repeat (2) @(posedge aclk);
    chk("irq_clr", 0, alarm_irq);
    rc("ctrl", rac_pkg::ADDR_CTRL, 8'h40);
    wr(rac_pkg::ADDR_IST, 8'h01);
    repeat (2) @(posedge aclk);
    chk("irq_w1c", 0, irq);
    wr(rac_pkg::ADDR_CTRL, 8'h01);
    wr(rac_pkg::ADDR_CTRL, 8'h00);
    repeat (3) @(posedge aclk);
    chk("irq_gated", 0, alarm_irq);
    rc("ctrl", rac_pkg::ADDR_CTRL, 8'h80);
    // Hour matches but weekday does not
    count_weekday <= 4'h3;
    wr(rac_pkg::ADDR_AEN, 8'h0C);
    wr(rac_pkg::ADDR_CTRL, 8'h01);
    wr(rac_pkg::ADDR_CTRL, 8'h00);
    repeat (3) @(posedge aclk);
    rc("partial", rac_pkg::ADDR_CTRL, 8'h00);
    wr(rac_pkg::ADDR_CTRL, 8'h04);
    rc("dst", rac_pkg::ADDR_CTRL, 8'h04);
    chk("dst_fx", 2'b01, {bcd_mode, osc_enable});
    // Alarm while asleep, then a bus reset must keep the cause
    wr(rac_pkg::ADDR_AEN, 8'h04);
    sleep_mode <= 1'b1;
    wr(rac_pkg::ADDR_CTRL, 8'h01);
    wr(rac_pkg::ADDR_CTRL, 8'h00);
    repeat (3) @(posedge aclk);
    chk("wakes", 1, wakes);
    rc("ist_wake", rac_pkg::ADDR_IST, 8'h03);
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    sleep_mode <= 1'b0;
    rc("ctrl_kept", rac_pkg::ADDR_CTRL, 8'h82);
    rc("ctrl_rdclr", rac_pkg::ADDR_CTRL, 8'h00);
    rc("alarm_hour_value_kept", rac_pkg::ADDR_ALARM_HOUR_VALUE, 8'hAB);
    rc("wday_kept", rac_pkg::ADDR_AWDAY, 8'h05);
    rc("aen_rst", rac_pkg::ADDR_AEN, 8'h00);
    // Line source: 50 then 60 edges of an 8-cycle wave per tick
    wr(rac_pkg::ADDR_CTRL, 8'h18);
    chk("osc_off", 0, osc_enable);
    repeat (3) wt();
    chk("gap50", 50 * 8, gap);
    wr(rac_pkg::ADDR_CTRL, 8'h10);
    repeat (3) wt();
    chk("gap60", 60 * 8, gap);
    repeat (200) @(posedge aclk);
    wr(rac_pkg::ADDR_CTRL, 8'h10);
    wt();
    chk("prescale_rst", 1, n > 400);
    // Match on a count step of the seconds field
    wr(rac_pkg::ADDR_AEN, 8'h01);
    wr(rac_pkg::ADDR_CTRL, 8'h50);
    alarm_second_setpoint <= count_second + 8'h01;
    rd(rac_pkg::ADDR_CTRL);
    repeat (3) @(posedge aclk);
    chk("pre_step", 0, alarm_irq);
    wt();
    repeat (3) @(posedge aclk);
    chk("step_alarm", 1, alarm_irq);
    wr(rac_pkg::ADDR_CTRL, 8'h11);
    k = 0;
    repeat (1000) begin
      @(posedge aclk);
      if (count_tick === 1'b1) k++;
    end
    chk("unlocked_ticks", 0, k);
    rc("unmapped", 12'h000, 8'h00);
    chk("rresp", rac_pkg::RESP_SLVERR, resp);
    wr(12'h004, 8'h5A);
    chk("bresp", rac_pkg::RESP_SLVERR, resp);
    stop_test();
  end
endmodule

`default_nettype wire
